// ### hw/mbsh_status_handler.sv
`timescale 1ns/10ps
`include "mbsh_regs.svh"

// Overview of operation
// - bad crc frames dropped, no reply
// - invalid request answered with exception, msb set
// - exception codes: function, register, quantity
// - out-of-range writes clamped and echoed
// - broadcast reads ignored, broadcast writes executed
// - coil write only for serially set outputs
// - output function selector codes zero to five
// - coils one to four map outputs
// - status one low bits show alarms
// - status one bits eight-ten hardware type
// - status two mode, run, action bits
// - status two tune, inhibit, unit bits
// - status two bits eleven-fourteen output states
// - status three conversion error flags
// - line rate code selects eight rates
module mbsh_status_handler
  import mbsh_pkg::*;
#(
  parameter int CLK_HZ = `MBSH_CLK_HZ
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_end,
  input  wire logic [7:0]  slave_addr,
  input  wire logic [2:0]  line_rate_code,
  output logic             rate_tick,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  output logic [15:0]      par_addr,
  input  wire logic [15:0] par_rdata,
  input  wire logic [15:0] par_min,
  input  wire logic [15:0] par_max,
  output logic             par_wr,
  output logic [15:0]      par_wdata,
  input  wire logic [11:0] out_func,
  input  wire logic [3:0]  output_state,
  output logic [3:0]       coil_set,
  input  wire logic [3:0]  alarm_active,
  input  wire logic [2:0]  hw_type,
  input  wire logic        auto_mode,
  input  wire logic        running,
  input  wire logic        direct_action,
  input  wire logic        autotune,
  input  wire logic [3:0]  pwrup_inhibit,
  input  wire logic        unit_fahrenheit,
  input  wire logic [7:0]  conv_err,
  output logic [15:0]      status_word1,
  output logic [15:0]      status_word2,
  output logic [15:0]      status_word3
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBSH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic [15:0] rate_div(input logic [2:0] code);
    int baud;
    case (code)
      3'h0:    baud = `MBSH_BAUD0;
      3'h1:    baud = `MBSH_BAUD1;
      3'h2:    baud = `MBSH_BAUD2;
      3'h3:    baud = `MBSH_BAUD3;
      3'h4:    baud = `MBSH_BAUD4;
      3'h5:    baud = `MBSH_BAUD5;
      3'h6:    baud = `MBSH_BAUD6;
      default: baud = `MBSH_BAUD7;
    endcase
    return 16'(CLK_HZ / baud);
  endfunction : rate_div

  function automatic logic [7:0] check_req(input logic [7:0]  fn,
                                           input logic [15:0] ra,
                                           input logic [15:0] rv,
                                           input logic [4:0]  len);
    logic [16:0] last;
    logic [7:0]  e;
    last = {1'b0, ra} + {1'b0, rv} - 17'h1;
    e    = `MBSH_EXC_NONE;
    case (fn)
      `MBSH_FN_RD_COILS: begin
        if (len != `MBSH_REQ_LEN || rv == 16'h0 || rv > `MBSH_NUM_COILS)
          e = `MBSH_EXC_QTY;
        else if (last >= {1'b0, `MBSH_NUM_COILS})
          e = `MBSH_EXC_ADDR;
      end
      `MBSH_FN_RD_HOLD: begin
        if (len != `MBSH_REQ_LEN || rv == 16'h0 || rv > `MBSH_MAX_RD_QTY)
          e = `MBSH_EXC_QTY;
        else if (!(last <= {1'b0, `MBSH_PAR_LAST} ||
                   (ra >= `MBSH_STAT1_REG &&
                    last <= {1'b0, `MBSH_STAT3_REG})))
          e = `MBSH_EXC_ADDR;
      end
      `MBSH_FN_WR_COIL: begin
        if (len != `MBSH_REQ_LEN)
          e = `MBSH_EXC_QTY;
        else if (ra >= `MBSH_NUM_COILS)
          e = `MBSH_EXC_ADDR;
        else if (rv != `MBSH_COIL_ON && rv != `MBSH_COIL_OFF)
          e = `MBSH_EXC_QTY;
      end
      `MBSH_FN_WR_REG: begin
        if (len != `MBSH_REQ_LEN)
          e = `MBSH_EXC_QTY;
        // status words are read-only
        else if (ra < `MBSH_PAR_WR_FIRST || ra > `MBSH_PAR_LAST)
          e = `MBSH_EXC_ADDR;
      end
      default: e = `MBSH_EXC_FUNC;
    endcase
    return e;
  endfunction : check_req

  logic [3:0] serial_out;
  for (genvar g = 0; g < 4; g++) begin : g_outf
    assign serial_out[g] =
      out_func[g*`MBSH_OUTF_W +: `MBSH_OUTF_W] == `MBSH_OUTF_SERIAL;
  end

  // status words
  logic [15:0] sw1_d, sw2_d, sw3_d;
  always_comb begin
    sw1_d = 16'h0000;
    sw2_d = 16'h0000;
    sw3_d = 16'h0000;
    sw1_d[`MBSH_SW1_ALARM +: 4]   = alarm_active;
    sw1_d[`MBSH_SW1_HWTYPE +: 3]  = hw_type;
    sw2_d[`MBSH_SW2_AUTO]         = auto_mode;
    sw2_d[`MBSH_SW2_RUN]          = running;
    sw2_d[`MBSH_SW2_DIRECT]       = direct_action;
    sw2_d[`MBSH_SW2_TUNE]         = autotune;
    sw2_d[`MBSH_SW2_INHIBIT +: 4] = pwrup_inhibit;
    sw2_d[`MBSH_SW2_UNIT]         = unit_fahrenheit;
    sw2_d[`MBSH_SW2_OUTPUT +: 4]  = output_state;
    sw3_d[5:0]                    = conv_err[5:0] & `MBSH_SW3_LOWMASK;
    sw3_d[`MBSH_SW3_CJ]           = conv_err[`MBSH_SW3_CJ];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status_word1 <= 16'h0000;
      status_word2 <= 16'h0000;
      status_word3 <= 16'h0000;
    end else begin
      status_word1 <= sw1_d;
      status_word2 <= sw2_d;
      status_word3 <= sw3_d;
    end
  end

  // line rate divider
  logic [15:0] rate_cnt_q, rate_cnt_d;
  logic        rate_tick_d;
  always_comb begin
    rate_tick_d = rate_cnt_q >= rate_div(line_rate_code) - 16'h1;
    rate_cnt_d  = rate_tick_d ? 16'h0000 : rate_cnt_q + 16'h1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rate_cnt_q <= 16'h0000;
      rate_tick  <= 1'b0;
    end else begin
      rate_cnt_q <= rate_cnt_d;
      rate_tick  <= rate_tick_d;
    end
  end

  // request engine
  mbsh_state_type    state_q, state_d;
  mbsh_kind_type     kind_q, kind_d;
  logic [4:0]        cnt_q, cnt_d;
  logic              ovf_q, ovf_d;
  logic [15:0]       crc_q, crc_d;
  logic [8:0]        idx_q, idx_d, tot_q, tot_d, off;
  logic [47:0]       f_q, f_d;
  logic [7:0]        fn_out_q, fn_out_d, exc_q, exc_d, exc_c;
  logic [15:0]       word_q, word_d;
  logic              wait_q, wait_d;
  logic [7:0]        tx_data_d, rd_data;
  logic              tx_valid_d, tx_last_d, par_wr_d, wr_en;
  logic [15:0]       par_addr_d, par_wdata_d, clamp;
  logic [3:0]        coil_set_d;
  logic              bcast, mine, is_read;
  logic [7:0]        f_slv, f_fn;
  logic [15:0]       f_ra, f_rv;

  assign f_slv   = f_q[47:40];
  assign f_fn    = f_q[39:32];
  assign f_ra    = f_q[31:16];
  assign f_rv    = f_q[15:0];
  assign bcast   = f_slv == `MBSH_BCAST_ADDR;
  assign mine    = bcast || f_slv == slave_addr;
  assign is_read = f_fn == `MBSH_FN_RD_COILS || f_fn == `MBSH_FN_RD_HOLD;
  assign exc_c   = check_req(f_fn, f_ra, f_rv, cnt_q);
  assign off     = idx_q - 9'h003;

  mbsh_frame_mem u_mem (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (wr_en),
    .wr_addr (cnt_q[`MBSH_BUF_AW-1:0]),
    .wr_data (rx_data),
    .rd_addr (idx_q[`MBSH_BUF_AW-1:0]),
    .rd_data (rd_data)
  );

  always_comb begin
    state_d     = state_q;
    kind_d      = kind_q;
    cnt_d       = cnt_q;
    ovf_d       = ovf_q;
    crc_d       = crc_q;
    idx_d       = idx_q;
    tot_d       = tot_q;
    f_d         = f_q;
    fn_out_d    = fn_out_q;
    exc_d       = exc_q;
    word_d      = word_q;
    wait_d      = 1'b0;
    tx_data_d   = tx_data;
    tx_valid_d  = tx_valid;
    tx_last_d   = tx_last;
    par_addr_d  = par_addr;
    par_wdata_d = par_wdata;
    par_wr_d    = 1'b0;
    coil_set_d  = coil_set;
    wr_en       = 1'b0;
    clamp       = f_rv;
    if ($signed(f_rv) < $signed(par_min))
      clamp = par_min;
    else if ($signed(f_rv) > $signed(par_max))
      clamp = par_max;
    case (state_q)
      ST_IDLE: begin
        if (rx_valid) begin
          if (cnt_q < 5'(`MBSH_BUF_DEPTH)) begin
            wr_en = 1'b1;
            cnt_d = cnt_q + 5'h01;
            crc_d = crc_step(crc_q, rx_data);
          end else begin
            ovf_d = 1'b1;
          end
        end
        if (rx_end)
          state_d = ST_CHECK;
      end
      ST_CHECK: begin
        idx_d = 9'h000;
        if (ovf_q || cnt_q < `MBSH_MIN_LEN || crc_q != 16'h0000)
          state_d = ST_IDLE;
        else
          state_d = ST_PARSE;
      end
      ST_PARSE: begin
        idx_d = idx_q + 9'h001;
        if (idx_q != 9'h000)
          f_d = {f_q[39:0], rd_data};
        if (idx_q == {5'h00, `MBSH_HDR_LAST})
          state_d = ST_DECIDE;
      end
      ST_DECIDE: begin
        idx_d    = 9'h000;
        crc_d    = `MBSH_CRC_INIT;
        fn_out_d = f_fn;
        exc_d    = exc_c;
        state_d  = ST_LOAD;
        if (!mine || (bcast && is_read)) begin
          state_d = ST_IDLE;
        end else if (exc_c != `MBSH_EXC_NONE) begin
          kind_d   = KIND_EXC;
          tot_d    = `MBSH_LEN_EXC;
          fn_out_d = f_fn | `MBSH_FN_EXC_FLAG;
          if (bcast)
            state_d = ST_IDLE;
        end else if (f_fn == `MBSH_FN_WR_COIL) begin
          if (serial_out[f_ra[1:0]])
            coil_set_d[f_ra[1:0]] = f_rv == `MBSH_COIL_ON;
          kind_d = KIND_ECHO;
          tot_d  = `MBSH_LEN_ECHO;
          if (bcast)
            state_d = ST_IDLE;
        end else if (f_fn == `MBSH_FN_WR_REG) begin
          par_addr_d = f_ra;
          state_d    = ST_WLIM;
        end else if (f_fn == `MBSH_FN_RD_COILS) begin
          kind_d = KIND_RD1;
          tot_d  = `MBSH_LEN_RDCOIL;
        end else begin
          kind_d = KIND_RD3;
          tot_d  = `MBSH_RD_OVERHEAD + {f_rv[7:0], 1'b0};
        end
      end
      ST_WLIM: begin
        wait_d = 1'b1;
        if (wait_q) begin
          par_wr_d    = 1'b1;
          par_wdata_d = clamp;
          f_d[15:0]   = clamp;
          kind_d      = KIND_ECHO;
          tot_d       = `MBSH_LEN_ECHO;
          state_d     = bcast ? ST_IDLE : ST_LOAD;
        end
      end
      ST_LOAD: begin
        tx_valid_d = 1'b1;
        tx_last_d  = idx_q == tot_q - 9'h001;
        state_d    = ST_SEND;
        if (idx_q == tot_q - 9'h002)
          tx_data_d = crc_q[7:0];
        else if (idx_q == tot_q - 9'h001)
          tx_data_d = crc_q[15:8];
        else if (idx_q == 9'h000)
          tx_data_d = f_slv;
        else if (idx_q == 9'h001)
          tx_data_d = fn_out_q;
        else begin
          case (kind_q)
            KIND_EXC:  tx_data_d = exc_q;
            KIND_ECHO: tx_data_d = f_q[8*(3'h5 - idx_q[2:0]) +: 8];
            KIND_RD1:  tx_data_d = (idx_q == 9'h002) ? 8'h01 :
                                   {4'h0, 4'(output_state >> f_ra[1:0]) &
                                    ~4'(4'hf << f_rv[2:0])};
            default: begin
              if (idx_q == 9'h002)
                tx_data_d = {f_rv[6:0], 1'b0};
              else if (off[0])
                tx_data_d = word_q[7:0];
              else begin
                tx_valid_d = 1'b0;
                par_addr_d = f_ra + {8'h00, off[8:1]};
                state_d    = ST_FETCH;
              end
            end
          endcase
        end
      end
      ST_FETCH: begin
        state_d = ST_GRAB;
      end
      ST_GRAB: begin
        case (par_addr)
          `MBSH_STAT1_REG: word_d = status_word1;
          `MBSH_STAT2_REG: word_d = status_word2;
          `MBSH_STAT3_REG: word_d = status_word3;
          default:         word_d = par_rdata;
        endcase
        tx_data_d  = word_d[15:8];
        tx_valid_d = 1'b1;
        tx_last_d  = 1'b0;
        state_d    = ST_SEND;
      end
      ST_SEND: begin
        if (tx_ready) begin
          tx_valid_d = 1'b0;
          idx_d      = idx_q + 9'h001;
          if (idx_q < tot_q - 9'h002)
            crc_d = crc_step(crc_q, tx_data);
          state_d = tx_last ? ST_IDLE : ST_LOAD;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (state_d == ST_IDLE && state_q != ST_IDLE) begin
      cnt_d = 5'h00;
      ovf_d = 1'b0;
      crc_d = `MBSH_CRC_INIT;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      kind_q    <= KIND_EXC;
      cnt_q     <= 5'h00;
      ovf_q     <= 1'b0;
      crc_q     <= `MBSH_CRC_INIT;
      idx_q     <= 9'h000;
      tot_q     <= 9'h000;
      f_q       <= 48'h0;
      fn_out_q  <= 8'h00;
      exc_q     <= 8'h00;
      word_q    <= 16'h0000;
      wait_q    <= 1'b0;
      tx_data   <= 8'h00;
      tx_valid  <= 1'b0;
      tx_last   <= 1'b0;
      par_addr  <= 16'h0000;
      par_wdata <= 16'h0000;
      par_wr    <= 1'b0;
      coil_set  <= 4'h0;
    end else begin
      state_q   <= state_d;
      kind_q    <= kind_d;
      cnt_q     <= cnt_d;
      ovf_q     <= ovf_d;
      crc_q     <= crc_d;
      idx_q     <= idx_d;
      tot_q     <= tot_d;
      f_q       <= f_d;
      fn_out_q  <= fn_out_d;
      exc_q     <= exc_d;
      word_q    <= word_d;
      wait_q    <= wait_d;
      tx_data   <= tx_data_d;
      tx_valid  <= tx_valid_d;
      tx_last   <= tx_last_d;
      par_addr  <= par_addr_d;
      par_wdata <= par_wdata_d;
      par_wr    <= par_wr_d;
      coil_set  <= coil_set_d;
    end
  end

  crc_drop_a: assert property (
    state_q == ST_CHECK && crc_q != 16'h0000 |=> state_q == ST_IDLE ##1
    !tx_valid [*4])
    else $error("bad crc frame not dropped");
  exc_msb_a: assert property (
    tx_valid && kind_q == KIND_EXC && idx_q == 9'h001 |-> tx_data[7])
    else $error("exception function byte lacks msb");
  exc_code_a: assert property (
    state_q == ST_DECIDE && mine && !is_read &&
    f_fn != `MBSH_FN_WR_COIL && f_fn != `MBSH_FN_WR_REG
    |=> exc_q == `MBSH_EXC_FUNC && kind_q == KIND_EXC)
    else $error("unsupported function not coded one");
  clamp_a: assert property (
    par_wr |-> !($signed(par_wdata) < $signed($past(par_min))) &&
               !($signed(par_wdata) > $signed($past(par_max))))
    else $error("written value outside limits");
  bcast_read_a: assert property (
    state_q == ST_DECIDE && bcast && is_read |=> state_q == ST_IDLE)
    else $error("broadcast read not ignored");
  coil_gate_a: assert property (
    ((coil_set ^ $past(coil_set)) & ~$past(serial_out)) == 4'h0)
    else $error("non-serial output altered");
  rate_tick_a: assert property (
    rate_tick && $stable(line_rate_code) ##1 $stable(line_rate_code)
    |-> rate_cnt_q == 16'h0001)
    else $error("rate divider misaligned");
  alarm_bits_a: assert property (
    status_word1[3:0] == $past(alarm_active) &&
    status_word1[10:8] == $past(hw_type))
    else $error("status one alarm or type wrong");
  out_bits_a: assert property (
    status_word2[14:11] == $past(output_state))
    else $error("status two output bits wrong");
  resv_zero_a: assert property (
    (status_word1 & `MBSH_SW1_RESV) == 16'h0 &&
    (status_word2 & `MBSH_SW2_RESV) == 16'h0 &&
    (status_word3 & `MBSH_SW3_RESV) == 16'h0)
    else $error("reserved status bit set");

endmodule : mbsh_status_handler

// ### hw/mbsh_regs.svh
`ifndef MBSH_REGS_SVH
`define MBSH_REGS_SVH

// function codes
`define MBSH_FN_RD_COILS   8'h01
`define MBSH_FN_RD_HOLD    8'h03
`define MBSH_FN_WR_COIL    8'h05
`define MBSH_FN_WR_REG     8'h06
`define MBSH_FN_EXC_FLAG   8'h80

// exception codes
`define MBSH_EXC_NONE      8'h00
`define MBSH_EXC_FUNC      8'h01
`define MBSH_EXC_ADDR      8'h02
`define MBSH_EXC_QTY       8'h03

`define MBSH_BCAST_ADDR    8'h00
`define MBSH_COIL_ON       16'hff00
`define MBSH_COIL_OFF      16'h0000
`define MBSH_NUM_COILS     16'h0004
`define MBSH_MAX_RD_QTY    16'h007d

// register number space
`define MBSH_PAR_LAST      16'h0070
`define MBSH_PAR_WR_FIRST  16'h000d
`define MBSH_STAT1_REG     16'h0200
`define MBSH_STAT2_REG     16'h0201
`define MBSH_STAT3_REG     16'h0202

// output function selector codes
`define MBSH_OUTF_SERIAL   3'h0
`define MBSH_OUTF_PWM      3'h1
`define MBSH_OUTF_ALARM1   3'h2
`define MBSH_OUTF_ALARM2   3'h3
`define MBSH_OUTF_ALOR     3'h4
`define MBSH_OUTF_LBD      3'h5
`define MBSH_OUTF_W        3

// crc
`define MBSH_CRC_INIT      16'hffff
`define MBSH_CRC_POLY      16'ha001

// frame buffer and lengths
`define MBSH_BUF_DEPTH     16
`define MBSH_BUF_AW        4
`define MBSH_REQ_LEN       5'h08
`define MBSH_MIN_LEN       5'h04
`define MBSH_HDR_LAST      4'h6
`define MBSH_LEN_EXC       9'h005
`define MBSH_LEN_ECHO      9'h008
`define MBSH_LEN_RDCOIL    9'h006
`define MBSH_RD_OVERHEAD   9'h005

// clock in Hz, line rates in bit/s
`define MBSH_CLK_HZ        40000000
`define MBSH_BAUD0         1200
`define MBSH_BAUD1         2400
`define MBSH_BAUD2         4800
`define MBSH_BAUD3         9600
`define MBSH_BAUD4         19200
`define MBSH_BAUD5         32400
`define MBSH_BAUD6         57600
`define MBSH_BAUD7         115200

// status word field positions
`define MBSH_SW1_ALARM     0
`define MBSH_SW1_HWTYPE    8
`define MBSH_SW2_AUTO      0
`define MBSH_SW2_RUN       1
`define MBSH_SW2_DIRECT    2
`define MBSH_SW2_TUNE      4
`define MBSH_SW2_INHIBIT   5
`define MBSH_SW2_UNIT      9
`define MBSH_SW2_OUTPUT    11
`define MBSH_SW3_LOWMASK   6'h3f
`define MBSH_SW3_CJ        7
`define MBSH_SW1_RESV      16'hf8f0
`define MBSH_SW2_RESV      16'h8408
`define MBSH_SW3_RESV      16'hff40

`endif

// ### hw/mbsh_pkg.sv
package mbsh_pkg;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_CHECK  = 9'h002,
    ST_PARSE  = 9'h004,
    ST_DECIDE = 9'h008,
    ST_WLIM   = 9'h010,
    ST_LOAD   = 9'h020,
    ST_FETCH  = 9'h040,
    ST_GRAB   = 9'h080,
    ST_SEND   = 9'h100
  } mbsh_state_type;

  typedef enum logic [1:0] {
    KIND_EXC  = 2'h0,
    KIND_ECHO = 2'h1,
    KIND_RD1  = 2'h2,
    KIND_RD3  = 2'h3
  } mbsh_kind_type;

endpackage : mbsh_pkg

// ### hw/mbsh_frame_mem.sv
`timescale 1ns/10ps
`include "mbsh_regs.svh"

module mbsh_frame_mem (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    wr_en,
  input  wire logic [`MBSH_BUF_AW-1:0] wr_addr,
  input  wire logic [7:0]              wr_data,
  input  wire logic [`MBSH_BUF_AW-1:0] rd_addr,
  output logic      [7:0]              rd_data
);

  logic [7:0] mem_q [`MBSH_BUF_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : mbsh_frame_mem

// ### verification/mbsh_master_model.sv
`timescale 1ns/10ps

module mbsh_master_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_end
);
  initial begin
    tx_ready = 1'b0;
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    rx_end   = 1'b0;
  end

  // slow mode stalls every other cycle
  always @(negedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  // eight bytes msb first, then end of frame
  task send(input logic [63:0] fr);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk);
      rx_data  <= fr[8*i+:8];
      rx_valid <= 1'b1;
      @(negedge clk);
      rx_valid <= 1'b0;
      rx_data  <= ~fr[8*i+:8];
    end
    rx_end <= 1'b1;
    @(negedge clk);
    rx_end <= 1'b0;
  endtask : send
endmodule : mbsh_master_model

// ### verification/mbsh_status_handler_tb.sv
`timescale 1ns/10ps
`include "mbsh_regs.svh"

module mbsh_status_handler_tb;
  logic        clk, reset, rx_valid, rx_end, tx_valid, tx_last, tx_ready;
  logic        slow, rate_tick, par_wr;
  logic [7:0]  rx_data, tx_data;
  logic [2:0]  rate;
  logic [15:0] par_addr, par_wdata, par_last, sw1, sw2, sw3;
  logic [15:0] ew[3];
  logic [11:0] out_func;
  logic [3:0]  coil_set;
  logic [31:0] stat, seed;
  logic [47:0] ex_req[4];
  logic [8:0]  exp_q[$];
  int          error_cnt, n_tests, wr_cnt, n, wr;
  int          bauds[8];

  mbsh_status_handler #(.CLK_HZ(400000)) mbsh_status_handler_inst (
    .clk(clk), .reset(reset), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_end(rx_end), .slave_addr(8'h11), .line_rate_code(rate),
    .rate_tick(rate_tick), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .par_addr(par_addr),
    .par_rdata(par_addr ^ 16'h5a5a), .par_min(16'hfff0),
    .par_max(16'h0100), .par_wr(par_wr), .par_wdata(par_wdata),
    .out_func(out_func), .output_state(stat[27:24]), .coil_set(coil_set),
    .alarm_active(stat[3:0]), .hw_type(stat[6:4]), .auto_mode(stat[7]),
    .running(stat[8]), .direct_action(stat[9]), .autotune(stat[10]),
    .pwrup_inhibit(stat[14:11]), .unit_fahrenheit(stat[15]),
    .conv_err(stat[23:16]), .status_word1(sw1), .status_word2(sw2),
    .status_word3(sw3));

  mbsh_master_model mbsh_master_model_inst (
    .clk(clk), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function automatic logic [15:0] crc(input logic [63:0] b, input int k);
    logic [15:0] c;
    c = `MBSH_CRC_INIT;
    for (int i = k - 1; i >= 0; i--) begin
      c ^= {8'h00, b[8*i+:8]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? (c >> 1) ^ `MBSH_CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // request with optional crc damage, reply of k bytes plus crc
  task txn(input logic [47:0] b, input logic [15:0] bad,
           input logic [47:0] r, input int k);
    logic [15:0] c;
    c = crc({16'h0, r}, k);
    for (int i = k - 1; i >= 0; i--)
      exp_q.push_back({1'b0, r[8*i+:8]});
    if (k > 0) begin
      exp_q.push_back({1'b0, c[7:0]});
      exp_q.push_back({1'b1, c[15:8]});
    end
    c = crc({16'h0, b}, 6) ^ bad;
    mbsh_master_model_inst.send({b, c[7:0], c[15:8]});
    for (int i = 0; i < 300 && exp_q.size() > 0; i++)
      @(negedge clk);
    repeat (20) @(negedge clk);
    chk(16'(exp_q.size()), 16'h0000);
  endtask : txn

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tx_valid && tx_ready) begin
      if (exp_q.size() == 0)
        chk({7'h0, tx_last, tx_data}, 16'hffff);
      else
        chk({7'h0, tx_last, tx_data}, {7'h0, exp_q.pop_front()});
    end
    if (par_wr) begin
      wr_cnt++;
      par_last = par_wdata;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    bauds = '{1200, 2400, 4800, 9600, 19200, 32400, 57600, 115200};
    ex_req = '{48'h1110_0000_0001, 48'h1103_0300_0001,
               48'h1103_0010_0000, 48'h1106_0201_0001};
    seed = 32'd44723;
    {stat, out_func, rate, slow, reset} = '0;
    reset = 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    txn(48'h1106_0010_0200, 0, 48'h1106_0010_0100, 6);
    chk(par_last, 16'h0100);
    slow = 1'b1;
    txn(48'h1106_0010_8000, 0, 48'h1106_0010_fff0, 6);
    chk(par_last, 16'hfff0);
    wr = wr_cnt;
    txn(48'h1106_0010_0005, 16'h0001, 48'h0, 0);
    chk(16'(wr_cnt - wr), 16'h0000);
    for (int i = 0; i < 4; i++)
      txn(ex_req[i], 0, {24'h0, 8'h11, ex_req[i][39:32] | 8'h80,
          (i == 3) ? 8'h02 : 8'(i + 1)}, 3);
    txn(48'h0003_0010_0001, 0, 48'h0, 0);
    txn(48'h0006_0010_0050, 0, 48'h0, 0);
    chk(16'(wr_cnt - wr), 16'h0001);
    chk(par_last, 16'h0050);
    for (int r = 0; r < 4; r++) begin
      seed = xs(seed);
      stat = seed;
      repeat (2) @(negedge clk);
      ew[0] = {5'h0, stat[6:4], 4'h0, stat[3:0]};
      ew[1] = {1'b0, stat[27:24], 1'b0, stat[15:11], stat[10], 1'b0,
               stat[9:7]};
      ew[2] = {8'h0, stat[23], 1'b0, stat[21:16]};
      chk(sw1, ew[0]);
      chk(sw2, ew[1]);
      chk(sw3, ew[2]);
      for (int j = 0; j < 3; j++)
        txn({32'h1103_0200 + j, 16'h0001}, 0,
            {8'h0, 24'h110302, ew[j]}, 5);
    end
    txn(48'h1103_0010_0001, 0, {8'h0, 24'h110302, 16'h5a4a}, 5);
    for (int f = 0; f < 6; f++) begin
      out_func = 12'(f) << 3;
      txn(48'h1105_0001_ff00, 0, 48'h1105_0001_ff00, 6);
      chk({12'h0, coil_set}, (f == 0) ? 16'h0002 : 16'h0000);
      txn(48'h1105_0001_0000, 0, 48'h1105_0001_0000, 6);
    end
    txn(48'h1105_0003_ff00, 0, 48'h1105_0003_ff00, 6);
    chk({12'h0, coil_set}, 16'h0008);
    txn(48'h1101_0000_0004, 0,
        {16'h0, 24'h110101, 4'h0, stat[27:24]}, 4);
    for (int c = 0; c < 8; c++) begin
      rate = 3'(c);
      repeat (3) begin
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (!rate_tick && n < 2000);
      end
      chk(16'(n), 16'(400000 / bauds[c]));
    end
    stop_test();
  end
endmodule : mbsh_status_handler_tb
